// [design/lcg_pkg.sv]
// Purpose: shared constants and types for the in-band loop code generator and detector
// Assumes: register index times four is the Wishbone byte address
// Notes: all offsets below are register indices
package lcg_pkg;

   localparam int unsigned ADR_W = 12;
   localparam int unsigned IDX_W = 10;

   // register indices
   localparam logic [IDX_W-1:0] IDX_LCC = 10'h124;
   localparam logic [IDX_W-1:0] IDX_TXP = 10'h125;
   localparam logic [IDX_W-1:0] IDX_RXA = 10'h126;
   localparam logic [IDX_W-1:0] IDX_RXD = 10'h127;
   localparam logic [IDX_W-1:0] IDX_STAT = 10'h130;
   localparam logic [IDX_W-1:0] IDX_MASK = 10'h131;
   localparam logic [IDX_W-1:0] IDX_STATE = 10'h132;

   // loop code control fields
   localparam int unsigned LCC_AUTO = 0;
   localparam int unsigned LCC_FRAMED = 1;
   localparam int unsigned LCC_TXLEN_LSB = 2;
   localparam int unsigned LCC_DLEN_LSB = 4;
   localparam int unsigned LCC_ALEN_LSB = 6;

   // pattern register fields
   localparam int unsigned PAT_EN = 0;
   localparam int unsigned PAT_LSB = 1;
   localparam int unsigned PAT_W = 7;

   // reset values
   localparam logic [7:0] LCC_RST = 8'h00;
   localparam logic [7:0] PAT_RST = 8'hAA;
   localparam logic [3:0] MASK_RST = 4'h0;

   // sticky event bits
   localparam int unsigned ST_ACT = 0;
   localparam int unsigned ST_DEACT = 1;
   localparam int unsigned ST_LOOP_ON = 2;
   localparam int unsigned ST_LOOP_OFF = 3;
   localparam int unsigned ST_W = 4;

   // live state bits
   localparam int unsigned LV_ACT = 0;
   localparam int unsigned LV_DEACT = 1;
   localparam int unsigned LV_LOOP = 2;

   // shortest code length, added to a two-bit length selector
   localparam logic [2:0] LEN_BASE = 3'h4;
   // consistent repeating bits needed after a window match before a code counts as present
   localparam logic [5:0] DET_RUN = 6'h27;

   localparam int unsigned DET_ACT = 0;
   localparam int unsigned DET_DEACT = 1;
   localparam int unsigned DET_N = 2;

   typedef struct packed {
      logic data;
      logic strobe;
      logic fbit;
   } lcg_bit_type;

   typedef enum logic {
      LP_OFF,
      LP_ON
   } lcg_loop_type;

endpackage

// [design/lcg_loop_code.sv]
// Purpose: in-band loop code generator, activation and deactivation detectors and automatic
//          remote loopback for loop code controller 0 of one T1 channel
// Assumes: line bit streams come from framer logic on clk_i, one bit per strobe cycle;
//          registers sit behind a classic Wishbone slave, one byte per aligned word
// Notes: ce_i low freezes every flip-flop, bus answers included
module lcg_loop_code (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [lcg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire lcg_pkg::lcg_bit_type tx_in_i,
   input wire lcg_pkg::lcg_bit_type rx_in_i,
   output lcg_pkg::lcg_bit_type tx_out_o,
   output logic remote_loop_o,
   output logic irq_o
);

   // pattern bit idx counted from the first bit sent or received
   function automatic logic code_bit(input logic [6:0] pat, input logic [2:0] idx);
      code_bit = pat[3'(3'h6 - idx)];
   endfunction

   // hist[0] is the newest bit; the last n bits must equal the pattern's top n bits
   function automatic logic win_match(input logic [6:0] hist, input logic [6:0] pat,
                                      input logic [2:0] n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (3'(i) < n && hist[i] != pat[3'(3'h7 - n + 3'(i))]) begin
            ok = 1'b0;
         end
      end
      win_match = ok;
   endfunction

   logic [7:0] lcc_r;
   logic [7:0] txp_r;
   logic [7:0] rxa_r;
   logic [7:0] rxd_r;
   logic [lcg_pkg::ST_W-1:0] stat_r;
   logic [lcg_pkg::ST_W-1:0] mask_r;
   logic [lcg_pkg::ST_W-1:0] stat_set;
   logic [lcg_pkg::ST_W-1:0] stat_clr;
   logic [2:0] tx_idx_r;
   lcg_pkg::lcg_loop_type loop_r;
   lcg_pkg::lcg_loop_type loop_nxt;
   wire [lcg_pkg::DET_N-1:0] det_lvl;
   wire [lcg_pkg::DET_N-1:0] det_rise;

   logic [lcg_pkg::IDX_W-1:0] idx;
   logic req;
   logic wr_lo;
   logic auto_en;
   logic framed;
   logic tx_en;
   logic [2:0] tx_len;
   logic [6:0] tx_pat;
   logic tx_take;
   logic act_hit;
   logic deact_hit;

   assign idx = wb_adr_i[lcg_pkg::ADR_W-1:2];
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lo = req & wb_we_i & wb_sel_i[0];
   assign auto_en = lcc_r[lcg_pkg::LCC_AUTO];
   assign framed = lcc_r[lcg_pkg::LCC_FRAMED];
   assign tx_en = txp_r[lcg_pkg::PAT_EN];
   assign tx_pat = txp_r[lcg_pkg::PAT_LSB +: lcg_pkg::PAT_W];
   // 00 gives 4 bits, each step adds one bit
   assign tx_len = 3'(lcg_pkg::LEN_BASE + {1'b0, lcc_r[lcg_pkg::LCC_TXLEN_LSB +: 2]});

   // ---------------- Wishbone slave ----------------

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i && req) begin
         unique case (idx)
            lcg_pkg::IDX_LCC: wb_dat_o <= {24'h00_0000, lcc_r};
            lcg_pkg::IDX_TXP: wb_dat_o <= {24'h00_0000, txp_r};
            lcg_pkg::IDX_RXA: wb_dat_o <= {24'h00_0000, rxa_r};
            lcg_pkg::IDX_RXD: wb_dat_o <= {24'h00_0000, rxd_r};
            lcg_pkg::IDX_STAT: wb_dat_o <= {28'h000_0000, stat_r};
            lcg_pkg::IDX_MASK: wb_dat_o <= {28'h000_0000, mask_r};
            lcg_pkg::IDX_STATE: wb_dat_o <= {29'h0000_0000, loop_r == lcg_pkg::LP_ON, det_lvl};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // control and pattern registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lcc_r <= lcg_pkg::LCC_RST;
         txp_r <= lcg_pkg::PAT_RST;
         rxa_r <= lcg_pkg::PAT_RST;
         rxd_r <= lcg_pkg::PAT_RST;
         mask_r <= lcg_pkg::MASK_RST;
      end else if (ce_i && wr_lo) begin
         unique case (idx)
            lcg_pkg::IDX_LCC: lcc_r <= wb_dat_i[7:0];
            lcg_pkg::IDX_TXP: txp_r <= wb_dat_i[7:0];
            lcg_pkg::IDX_RXA: rxa_r <= wb_dat_i[7:0];
            lcg_pkg::IDX_RXD: rxd_r <= wb_dat_i[7:0];
            lcg_pkg::IDX_MASK: mask_r <= wb_dat_i[lcg_pkg::ST_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- sticky events and interrupt ----------------

   always_comb begin
      stat_set = '0;
      stat_set[lcg_pkg::ST_ACT] = det_rise[lcg_pkg::DET_ACT];
      stat_set[lcg_pkg::ST_DEACT] = det_rise[lcg_pkg::DET_DEACT];
      stat_set[lcg_pkg::ST_LOOP_ON] = (loop_r == lcg_pkg::LP_OFF) && (loop_nxt == lcg_pkg::LP_ON);
      stat_set[lcg_pkg::ST_LOOP_OFF] = (loop_r == lcg_pkg::LP_ON) && (loop_nxt == lcg_pkg::LP_OFF);
   end

   assign stat_clr = (wr_lo && idx == lcg_pkg::IDX_STAT) ? wb_dat_i[lcg_pkg::ST_W-1:0] : '0;

   // a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_r <= '0;
      end else if (ce_i) begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(stat_r & mask_r);
      end
   end

   // ---------------- receive detectors ----------------

   // detector 0 searches the activation code, detector 1 the deactivation code
   for (genvar g = 0; g < lcg_pkg::DET_N; g++) begin : det_gen
      logic [6:0] hist_r;
      logic [6:0] hist_nxt;
      logic [5:0] run_r;
      logic lvl_r;
      logic rise_r;
      logic [7:0] reg_v;
      logic [6:0] pat;
      logic en;
      logic [2:0] len;
      logic take;
      logic same;

      assign reg_v = (g == lcg_pkg::DET_ACT) ? rxa_r : rxd_r;
      // msb of the expected code is the first bit off the line
      assign pat = reg_v[lcg_pkg::PAT_LSB +: lcg_pkg::PAT_W];
      assign en = reg_v[lcg_pkg::PAT_EN];
      // length from the control register, 00 gives 4 bits
      assign len = (g == lcg_pkg::DET_ACT) ?
                   3'(lcg_pkg::LEN_BASE + {1'b0, lcc_r[lcg_pkg::LCC_ALEN_LSB +: 2]}) :
                   3'(lcg_pkg::LEN_BASE + {1'b0, lcc_r[lcg_pkg::LCC_DLEN_LSB +: 2]});
      // framed format skips framing bits when matching
      assign take = rx_in_i.strobe & ~(framed & rx_in_i.fbit);
      assign hist_nxt = {hist_r[5:0], rx_in_i.data};
      // new bit repeats the one received one code length earlier
      assign same = rx_in_i.data == hist_r[3'(len - 3'h1)];

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            hist_r <= 7'h00;
            run_r <= 6'h00;
         end else if (ce_i) begin
            if (!en) begin
               hist_r <= 7'h00;
               run_r <= 6'h00;
            end else if (take) begin
               hist_r <= hist_nxt;
               if (run_r != 6'h00 && same) begin
                  run_r <= (run_r == lcg_pkg::DET_RUN) ? run_r : 6'(run_r + 6'h01);
               end else begin
                  run_r <= win_match(hist_nxt, pat, len) ? 6'h01 : 6'h00;
               end
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            lvl_r <= 1'b0;
            rise_r <= 1'b0;
         end else if (ce_i) begin
            lvl_r <= en && (run_r == lcg_pkg::DET_RUN);
            rise_r <= en && (run_r == lcg_pkg::DET_RUN) && !lvl_r;
         end
      end

      assign det_lvl[g] = lvl_r;
      assign det_rise[g] = rise_r;
   end

   // ---------------- automatic remote loopback, controller 0 only ----------------

   assign act_hit = auto_en & rxa_r[lcg_pkg::PAT_EN] & det_rise[lcg_pkg::DET_ACT];
   assign deact_hit = auto_en & rxd_r[lcg_pkg::PAT_EN] & det_rise[lcg_pkg::DET_DEACT];

   always_comb begin
      loop_nxt = loop_r;
      unique case (loop_r)
         lcg_pkg::LP_OFF: begin
            if (act_hit) begin
               loop_nxt = lcg_pkg::LP_ON;
            end
         end
         lcg_pkg::LP_ON: begin
            // turning automatic mode off also drops the loop
            if (deact_hit || !auto_en) begin
               loop_nxt = lcg_pkg::LP_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_r <= lcg_pkg::LP_OFF;
         remote_loop_o <= 1'b0;
      end else if (ce_i) begin
         loop_r <= loop_nxt;
         remote_loop_o <= loop_nxt == lcg_pkg::LP_ON;
      end
   end

   // ---------------- transmit generator ----------------

   // framing bits pass untouched only in framed format
   assign tx_take = tx_en & tx_in_i.strobe & ~(framed & tx_in_i.fbit);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_idx_r <= 3'h0;
      end else if (ce_i) begin
         if (!tx_en) begin
            tx_idx_r <= 3'h0;
         end else if (tx_take) begin
            // wraps after the last pattern bit, also if the length shrank
            tx_idx_r <= (tx_idx_r >= 3'(tx_len - 3'h1)) ? 3'h0 : 3'(tx_idx_r + 3'h1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_out_o <= '0;
      end else if (ce_i) begin
         tx_out_o.strobe <= tx_in_i.strobe;
         tx_out_o.fbit <= tx_in_i.fbit;
         // code bits go out msb first, otherwise the stream passes through
         tx_out_o.data <= tx_take ? code_bit(tx_pat, tx_idx_r) : tx_in_i.data;
      end
   end

endmodule

// [test/lcg_loop_code_sva.sv]
// Purpose: port-level checks of the loop code block
// Assumes: one clock, synchronous active-high reset
// Notes: read data is registered at the edge that takes the request
module lcg_loop_code_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [lcg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire lcg_pkg::lcg_bit_type tx_in_i,
   input wire lcg_pkg::lcg_bit_type rx_in_i,
   input wire lcg_pkg::lcg_bit_type tx_out_o,
   input wire logic remote_loop_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_ack_pulse;
      wb_ack_o && ce_i |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_ack_cause;
      !wb_ack_o && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_tx_timing;
      ce_i |=> tx_out_o.strobe == $past(tx_in_i.strobe) && tx_out_o.fbit == $past(tx_in_i.fbit);
   endproperty
   a_tx_timing: assert property (p_tx_timing) else $error("tx strobe or fbit delay wrong");
   property p_reset_quiet;
      disable iff (1'b0) rst_i |=> !wb_ack_o && !remote_loop_o && !irq_o && tx_out_o == 3'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
   property p_rd_upper;
      wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("read upper bits not zero");
   property p_rd_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h100 |-> wb_dat_o == 32'h0;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
   property p_state_loop;
      wb_ack_o && !wb_we_i && wb_adr_i[11:2] == lcg_pkg::IDX_STATE |-> wb_dat_o[2] == $past(remote_loop_o);
   endproperty
   a_state_loop: assert property (p_state_loop) else $error("state bit differs from loop");
   property p_loop_rise;
      $rose(remote_loop_o) |-> $past(rx_in_i.strobe, 3);
   endproperty
   a_loop_rise: assert property (p_loop_rise) else $error("loop entered without line bit");
endmodule
bind lcg_loop_code lcg_loop_code_sva u_sva (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_in_i, .rx_in_i, .tx_out_o,
   .remote_loop_o, .irq_o);

// [test/lcg_line_far_end.sv]
// Purpose: remote terminal sending a repeating loop code on the receive line
// Assumes: one line bit every clock, a framing bit every eighth bit
// Notes: idles at all ones, which matches no code holding a zero
module lcg_line_far_end (
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic [6:0] code_i,
   input wire logic [2:0] len_i,
   output lcg_pkg::lcg_bit_type rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] idx_r = 3'h0;
   logic [2:0] fcnt_r = 3'h0;
   initial rx_o = 3'h0;
   always @(posedge clk_i) begin
      fcnt_r <= fcnt_r + 3'h1;
      rx_o.strobe <= 1'b1;
      rx_o.fbit <= (fcnt_r == 3'h0);
      if (send_i) begin
         rx_o.data <= code_i[3'h6 - idx_r];
         idx_r <= (idx_r == len_i - 3'h1) ? 3'h0 : idx_r + 3'h1;
      end else begin
         rx_o.data <= 1'b1;
         idx_r <= 3'h0;
      end
   end
endmodule

// [test/testbench.sv]
// Purpose: register, generator and detector tests of the loop code block
// Assumes: clock enable high except in the freeze scenario at the end
// Notes: transmit input alternates data so pass-through is visible
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, loop, irq, tx_run = 1'b0, send = 1'b0, ce = 1'b1;
   logic [11:0] adr = 12'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic [2:0] tcnt = 3'h0, len = 3'h4;
   logic [6:0] code = 7'h60;
   lcg_pkg::lcg_bit_type tx_in, tx_out, rx_in;
   int failures = 0;
   int samples_checked = 0;
   logic [9:0] ri [8] = '{lcg_pkg::IDX_LCC, lcg_pkg::IDX_TXP, lcg_pkg::IDX_RXA, lcg_pkg::IDX_RXD,
      lcg_pkg::IDX_STAT, lcg_pkg::IDX_MASK, lcg_pkg::IDX_STATE, 10'h100};
   logic [7:0] rv [8] = '{8'h00, 8'hAA, 8'hAA, 8'hAA, 8'h00, 8'h00, 8'h00, 8'h00};
   always #5 clk_i = ~clk_i;
   assign tx_in = {tcnt[0], tx_run, tcnt == 3'h0};
   always @(posedge clk_i) tcnt <= tx_run ? tcnt + 3'h1 : 3'h0;
   lcg_loop_code DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tx_in_i(tx_in), .rx_in_i(rx_in), .tx_out_o(tx_out), .remote_loop_o(loop), .irq_o(irq));
   lcg_line_far_end u_far (.clk_i(clk_i), .send_i(send), .code_i(code), .len_i(len), .rx_o(rx_in));
   task automatic test_done;
      $display("compared %0d mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         failures++;
         test_done();
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rdc(input string what, input logic [9:0] idx, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      cmp(what, {24'h0, e}, r);
   endtask
   task automatic gen(input logic [1:0] l, input logic fr, input logic en, input logic [6:0] p);
      int i;
      logic e;
      i = 0;
      wr(lcg_pkg::IDX_LCC, {4'h0, l, fr, 1'b0});
      wr(lcg_pkg::IDX_TXP, {p, en});
      tx_run <= 1'b1;
      @(posedge clk_i);
      for (int k = 0; k < 24; k++) begin
         @(posedge clk_i);
         if (!en || (fr && k % 8 == 0)) begin
            e = k[0];
         end else begin
            e = p[6 - (i % (l + 4))];
            i++;
         end
         cmp("tx bit", {31'h0, e}, {31'h0, tx_out.data});
      end
      tx_run <= 1'b0;
      wr(lcg_pkg::IDX_TXP, {p, 1'b0});
   endtask
   task automatic wait_loop(input logic v);
      int n;
      n = 0;
      while (loop !== v && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      cmp("remote loop", {31'h0, v}, {31'h0, loop});
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(10'h100, 8'hFF);
      for (int j = 0; j < 8; j++) rdc("reset value", ri[j], rv[j]);
      for (int l = 0; l < 4; l++) gen(l[1:0], 1'b0, 1'b1, 7'h59);
      gen(2'h3, 1'b1, 1'b1, 7'h59);
      gen(2'h1, 1'b0, 1'b0, 7'h59);
      wr(lcg_pkg::IDX_LCC, 8'h11);
      wr(lcg_pkg::IDX_RXA, 8'hC0);
      wr(lcg_pkg::IDX_RXD, 8'hE1);
      send <= 1'b1;
      repeat (80) @(posedge clk_i);
      cmp("loop with detect off", 32'h0, {31'h0, loop});
      wr(lcg_pkg::IDX_RXA, 8'hC1);
      wait_loop(1'b1);
      rdc("status", lcg_pkg::IDX_STAT, 8'h05);
      rdc("state", lcg_pkg::IDX_STATE, 8'h05);
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(lcg_pkg::IDX_MASK, 8'h04);
      repeat (2) @(posedge clk_i);
      cmp("irq on", 32'h1, {31'h0, irq});
      wr(lcg_pkg::IDX_STAT, 8'h04);
      repeat (2) @(posedge clk_i);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      code <= 7'h70;
      len <= 3'h5;
      wait_loop(1'b0);
      rdc("status", lcg_pkg::IDX_STAT, 8'h0B);
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(lcg_pkg::IDX_STAT, 8'h0F);
      rdc("status", lcg_pkg::IDX_STAT, 8'h00);
      // 5-bit activation code 10100 arrives while the clock enable is low
      wr(lcg_pkg::IDX_LCC, 8'h51);
      wr(lcg_pkg::IDX_RXA, 8'hA1);
      ce <= 1'b0;
      code <= 7'h50;
      repeat (150) @(posedge clk_i);
      cmp("loop while frozen", 32'h0, {31'h0, loop});
      ce <= 1'b1;
      wait_loop(1'b1);
      rdc("status", lcg_pkg::IDX_STAT, 8'h05);
      test_done();
   end
endmodule
